//--- core/rvdc_pkg.sv
package rvdc_pkg;
    // fixed-point widths
    localparam int DUTY_W = 16;          // duty in 0.01 % steps, 10000 = 100 %
    localparam int PCT_FULL = 10000;
    localparam int VAL_W = 16;           // signed pressure / gain operands
    localparam int ACC_W = 32;           // integral accumulator
    localparam int VOLT_W = 16;          // battery voltage in mV
    localparam int RES_W = 16;           // coil resistance in milliohm
    localparam int CUR_W = 16;           // current in mA
    localparam int FREQ_W = 24;          // pwm period in clock cycles
    localparam int CHAN_W = 4;           // low-side channel assignment mask
    // current ceiling for a locked channel pair
    localparam int CURRENT_LIMIT_MA = 3000;
    // control update period, short enough that a bench run sees several updates
    localparam int CLK_HZ = 125000000;
    localparam int UPDATE_US = 100;
    localparam int UPDATE_CYCLES = (CLK_HZ / 1000000) * UPDATE_US;
    // integral and derivative operands are scaled by a shift
    localparam int GAIN_SHIFT = 8;
    // reset values
    localparam logic [DUTY_W-1:0] DUTY_RESET = 16'h0000;
    // which valve runs the pid controller
    typedef enum logic {RVDC_INLET_PID, RVDC_PRESSURE_PID} rvdc_mode_type;
endpackage

//--- core/rvdc_pwm.sv
`timescale 1ns/1ps
`default_nettype none
// one pwm channel: period in cycles, duty in 0.01 % steps
module rvdc_pwm
    import rvdc_pkg::*;
(
    input wire logic clk_sys_in, // system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic enable_in, // gate for the output
    input wire logic [FREQ_W-1:0] period_in, // period in cycles
    input wire logic [DUTY_W-1:0] duty_in, // duty, 0.01 % steps
    output logic pwm_out // registered pwm drive
);
    logic [FREQ_W-1:0] count_r;
    logic [FREQ_W-1:0] high_r;
    logic [FREQ_W+DUTY_W-1:0] prod;
    wire wrap = (count_r >= period_in - 24'h000001) || (period_in == 24'h000000);
    assign prod = period_in * duty_in;
    // high time latched at wrap so a period never glitches
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_r <= 24'h000000;
            high_r <= 24'h000000;
            pwm_out <= 1'b0;
        end else begin
            count_r <= wrap ? 24'h000000 : count_r + 24'h000001;
            if (wrap) begin
                high_r <= FREQ_W'(prod / PCT_FULL);
            end
            pwm_out <= enable_in && (count_r < high_r);
        end
    end
endmodule
`default_nettype wire

//--- core/rvdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rvdc_top
    import rvdc_pkg::*;
(
    input wire logic clk_sys_in, // 125 MHz clock
    input wire logic nrst_in, // async reset, active low
    input wire rvdc_pkg::rvdc_mode_type controlled_valve_select_in, // pid valve
    input wire logic signed [VAL_W-1:0] rail_setpoint_in, // pressure setpoint
    input wire logic signed [VAL_W-1:0] rail_pressure_in, // measured pressure
    input wire logic signed [VAL_W-1:0] rail_max_thresh_in, // fault threshold
    input wire logic clear_rail_fault_in, // clears latched fault
    input wire logic [VOLT_W-1:0] battery_voltage_in, // mV
    input wire logic inlet_valve_output_enable_in, // inlet enable
    input wire logic pressure_valve_output_enable_in, // pressure enable
    input wire logic [CHAN_W-1:0] inlet_valve_channel_assignment_in, // lock map
    input wire logic [CHAN_W-1:0] pressure_valve_channel_assignment_in, // lock map
    input wire logic [FREQ_W-1:0] inlet_valve_pwm_period_in, // cycles
    input wire logic [FREQ_W-1:0] pressure_valve_pwm_period_in, // cycles
    input wire logic [2*VAL_W-1:0] proportional_gain_in, // signed kc, {pressure,inlet}
    input wire logic [2*VAL_W-1:0] integral_time_in, // ti, {pressure,inlet}
    input wire logic [2*VAL_W-1:0] derivative_time_in, // td, {pressure,inlet}
    input wire logic [2*DUTY_W-1:0] controller_max_in, // pid max, {pressure,inlet}
    input wire logic [2*DUTY_W-1:0] controller_min_in, // pid min, {pressure,inlet}
    input wire logic [DUTY_W-1:0] inlet_valve_feed_forward_in, // pid ff
    input wire logic [DUTY_W-1:0] pressure_valve_feed_forward_in, // pid ff
    input wire logic [DUTY_W-1:0] inlet_valve_fixed_duty_in, // non-pid duty
    input wire logic [DUTY_W-1:0] pressure_valve_fixed_duty_in, // non-pid duty
    input wire logic inlet_valve_manual_flag_in, // manual override
    input wire logic pressure_valve_manual_flag_in, // manual override
    input wire logic [DUTY_W-1:0] inlet_valve_manual_duty_in, // manual duty
    input wire logic [DUTY_W-1:0] pressure_valve_manual_duty_in, // manual duty
    input wire logic [DUTY_W-1:0] inlet_valve_user_max_duty_in, // user max
    input wire logic [DUTY_W-1:0] pressure_valve_user_max_duty_in, // user max
    input wire logic [DUTY_W-1:0] inlet_valve_min_duty_in, // user min
    input wire logic [DUTY_W-1:0] pressure_valve_min_duty_in, // user min
    input wire logic [RES_W-1:0] inlet_valve_coil_resistance_in, // milliohm
    input wire logic [RES_W-1:0] pressure_valve_coil_resistance_in, // milliohm
    output logic inlet_valve_pwm_out, // to locked low-side pair
    output logic pressure_valve_pwm_out, // to locked low-side pair
    output logic [DUTY_W-1:0] inlet_valve_final_duty_out, // applied duty
    output logic [DUTY_W-1:0] pressure_valve_final_duty_out, // applied duty
    output logic [DUTY_W-1:0] inlet_valve_current_limit_duty_out, // computed max
    output logic [DUTY_W-1:0] pressure_valve_current_limit_duty_out, // computed max
    output logic [CUR_W-1:0] inlet_valve_current_estimate_out, // mA
    output logic [CUR_W-1:0] pressure_valve_current_estimate_out, // mA
    output logic [2*ACC_W-1:0] proportional_share_out, // {pressure,inlet}
    output logic [2*ACC_W-1:0] integral_share_out, // {pressure,inlet}
    output logic [2*ACC_W-1:0] derivative_share_out, // {pressure,inlet}
    output logic [CHAN_W-1:0] inlet_valve_channel_assignment_out, // reported map
    output logic [CHAN_W-1:0] pressure_valve_channel_assignment_out, // reported map
    output logic rail_fault_out, // latched overpressure
    output logic update_tick_out // one-cycle pulse per update
);
    import rvdc_pkg::*;

    // clamp a signed value into [lo, hi], returned as duty
    function automatic logic [DUTY_W-1:0] clamp_duty(input logic signed [ACC_W+1:0] v,
                                                     input logic [DUTY_W-1:0] lo,
                                                     input logic [DUTY_W-1:0] hi);
        logic [DUTY_W-1:0] r;
        r = DUTY_W'(v[DUTY_W-1:0]);
        if (v < $signed({2'b00, {(ACC_W-DUTY_W){1'b0}}, lo})) begin
            r = lo;
        end else if (v > $signed({2'b00, {(ACC_W-DUTY_W){1'b0}}, hi})) begin
            r = hi;
        end
        return r;
    endfunction

    // duty giving the 3 A ceiling: I*R/V, capped at full scale
    function automatic logic [DUTY_W-1:0] limit_duty(input logic [VOLT_W-1:0] mv,
                                                     input logic [RES_W-1:0] mohm);
        logic [47:0] q;
        q = (mv == 16'h0000) ? 48'(PCT_FULL) : 48'((48'(CURRENT_LIMIT_MA) * mohm * 48'(PCT_FULL)) / (48'(mv) * 48'd1000));
        return (q > 48'(PCT_FULL)) ? DUTY_W'(PCT_FULL) : DUTY_W'(q);
    endfunction

    // estimated current: duty * V / R in mA
    function automatic logic [CUR_W-1:0] est_current(input logic [DUTY_W-1:0] d,
                                                     input logic [VOLT_W-1:0] mv,
                                                     input logic [RES_W-1:0] mohm);
        logic [47:0] q;
        q = (mohm == 16'h0000) ? 48'h0 : 48'((48'(d) * mv * 48'd1000) / (48'(mohm) * 48'(PCT_FULL)));
        return (q > 48'h00000000ffff) ? 16'hffff : CUR_W'(q);
    endfunction

    // update tick divider
    logic [$clog2(UPDATE_CYCLES)-1:0] tick_cnt_r;
    wire tick = (tick_cnt_r == ($clog2(UPDATE_CYCLES))'(UPDATE_CYCLES - 1));
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // shared error term, setpoint minus measurement
    wire signed [VAL_W:0] err = rail_setpoint_in - rail_pressure_in;

    // two pid controllers, index 0 inlet, 1 pressure
    logic signed [ACC_W-1:0] integ_r [2];
    logic signed [VAL_W:0] err_prev_r;
    logic signed [ACC_W-1:0] p_term [2];
    logic signed [ACC_W-1:0] i_term [2];
    logic signed [ACC_W-1:0] d_term [2];
    logic signed [ACC_W+1:0] pid_sum [2];
    logic [DUTY_W-1:0] pid_lim [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pid
            wire signed [VAL_W-1:0] kc = proportional_gain_in[g*VAL_W +: VAL_W];
            wire [VAL_W-1:0] ti = integral_time_in[g*VAL_W +: VAL_W];
            wire [VAL_W-1:0] td = derivative_time_in[g*VAL_W +: VAL_W];
            wire active = (controlled_valve_select_in == rvdc_mode_type'(g));
            wire signed [ACC_W-1:0] kp_err = ACC_W'(kc * err);
            // kc zero forces every term to zero
            assign p_term[g] = kp_err;
            assign i_term[g] = (ti == 16'h0000 || kc == 16'sh0000) ? '0 : integ_r[g];
            assign d_term[g] = (td == 16'h0000) ? '0 :
                ACC_W'((kp_err - ACC_W'(kc * err_prev_r)) * $signed({1'b0, td}) >>> GAIN_SHIFT);
            assign pid_sum[g] = (ACC_W+2)'(p_term[g]) + (ACC_W+2)'(i_term[g]) + (ACC_W+2)'(d_term[g]);
            assign pid_lim[g] = clamp_duty(pid_sum[g], controller_min_in[g*DUTY_W +: DUTY_W],
                                           controller_max_in[g*DUTY_W +: DUTY_W]);
            // integrator advances once per tick, only on the pid valve; smaller ti gives more
            always_ff @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    integ_r[g] <= '0;
                end else if (tick) begin
                    if (!active || ti == 16'h0000) begin
                        integ_r[g] <= '0;
                    end else begin
                        integ_r[g] <= integ_r[g] + ACC_W'((kp_err <<< GAIN_SHIFT) / $signed({1'b0, ti}));
                    end
                end
            end
        end
    endgenerate

    // report each term per controller; one process owns each packed output
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            proportional_share_out <= '0;
            integral_share_out <= '0;
            derivative_share_out <= '0;
        end else if (tick) begin
            proportional_share_out <= {p_term[1], p_term[0]};
            integral_share_out <= {i_term[1], i_term[0]};
            derivative_share_out <= {d_term[1], d_term[0]};
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_prev_r <= '0;
        end else if (tick) begin
            err_prev_r <= err;
        end
    end

    // demand selection: manual, pid plus feed forward, or fixed duty
    wire inlet_pid = (controlled_valve_select_in == RVDC_INLET_PID);
    wire [DUTY_W:0] inlet_pidff = {1'b0, pid_lim[0]} + {1'b0, inlet_valve_feed_forward_in};
    wire [DUTY_W:0] press_pidff = {1'b0, pid_lim[1]} + {1'b0, pressure_valve_feed_forward_in};
    wire [DUTY_W:0] inlet_dem = inlet_valve_manual_flag_in ? {1'b0, inlet_valve_manual_duty_in} :
                                inlet_pid ? inlet_pidff : {1'b0, inlet_valve_fixed_duty_in};
    wire [DUTY_W:0] press_dem = pressure_valve_manual_flag_in ? {1'b0, pressure_valve_manual_duty_in} :
                                inlet_pid ? {1'b0, pressure_valve_fixed_duty_in} : press_pidff;

    // current-based ceiling and effective maximum
    wire [DUTY_W-1:0] inlet_lim = limit_duty(battery_voltage_in, inlet_valve_coil_resistance_in);
    wire [DUTY_W-1:0] press_lim = limit_duty(battery_voltage_in, pressure_valve_coil_resistance_in);
    wire [DUTY_W-1:0] inlet_max = (inlet_valve_user_max_duty_in < inlet_lim) ?
                                  inlet_valve_user_max_duty_in : inlet_lim;
    wire [DUTY_W-1:0] press_max = (pressure_valve_user_max_duty_in < press_lim) ?
                                  pressure_valve_user_max_duty_in : press_lim;
    // max wins over min if the user crosses them, to protect the coil
    wire [DUTY_W-1:0] inlet_fin = clamp_duty((ACC_W+2)'(inlet_dem),
        (inlet_valve_min_duty_in > inlet_max) ? inlet_max : inlet_valve_min_duty_in, inlet_max);
    wire [DUTY_W-1:0] press_fin = clamp_duty((ACC_W+2)'(press_dem),
        (pressure_valve_min_duty_in > press_max) ? press_max : pressure_valve_min_duty_in, press_max);

    // overpressure fault; a new excess wins over a clear
    wire over = (rail_pressure_in > rail_max_thresh_in);
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rail_fault_out <= 1'b0;
        end else if (over) begin
            rail_fault_out <= 1'b1;
        end else if (clear_rail_fault_in) begin
            rail_fault_out <= 1'b0;
        end
    end

    // limits and reported values refresh once per tick
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            inlet_valve_final_duty_out <= DUTY_RESET;
            pressure_valve_final_duty_out <= DUTY_RESET;
            inlet_valve_current_limit_duty_out <= DUTY_RESET;
            pressure_valve_current_limit_duty_out <= DUTY_RESET;
            inlet_valve_current_estimate_out <= '0;
            pressure_valve_current_estimate_out <= '0;
            update_tick_out <= 1'b0;
        end else begin
            update_tick_out <= tick;
            if (tick) begin
                inlet_valve_final_duty_out <= inlet_fin;
                pressure_valve_final_duty_out <= press_fin;
                inlet_valve_current_limit_duty_out <= inlet_lim;
                pressure_valve_current_limit_duty_out <= press_lim;
                inlet_valve_current_estimate_out <= est_current(inlet_fin, battery_voltage_in,
                                                                inlet_valve_coil_resistance_in);
                pressure_valve_current_estimate_out <= est_current(press_fin, battery_voltage_in,
                                                                   pressure_valve_coil_resistance_in);
            end
        end
    end

    // channel map is reported as configured
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            inlet_valve_channel_assignment_out <= '0;
            pressure_valve_channel_assignment_out <= '0;
        end else begin
            inlet_valve_channel_assignment_out <= inlet_valve_channel_assignment_in;
            pressure_valve_channel_assignment_out <= pressure_valve_channel_assignment_in;
        end
    end

    // pwm generators, gated by enable and fault
    wire inlet_en = inlet_valve_output_enable_in && !rail_fault_out && !over;
    wire press_en = pressure_valve_output_enable_in && !rail_fault_out && !over;
    rvdc_pwm u_inlet_pwm (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .enable_in(inlet_en),
        .period_in(inlet_valve_pwm_period_in),
        .duty_in(inlet_valve_final_duty_out),
        .pwm_out(inlet_valve_pwm_out)
    );
    rvdc_pwm u_press_pwm (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .enable_in(press_en),
        .period_in(pressure_valve_pwm_period_in),
        .duty_in(pressure_valve_final_duty_out),
        .pwm_out(pressure_valve_pwm_out)
    );

    a_fault_latch: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        over |=> rail_fault_out) else $error("overpressure did not latch fault");
    a_fault_off: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        rail_fault_out |=> !inlet_valve_pwm_out && !pressure_valve_pwm_out) else $error("pwm on during fault");
    a_inlet_enable: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !inlet_valve_output_enable_in |=> !inlet_valve_pwm_out) else $error("inlet pwm while disabled");
    a_press_enable: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !pressure_valve_output_enable_in |=> !pressure_valve_pwm_out) else $error("pressure pwm while disabled");
    a_final_max: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        tick |=> inlet_valve_final_duty_out <= $past(inlet_max)) else $error("inlet duty above maximum");
    a_final_min: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        tick && inlet_valve_min_duty_in <= inlet_max |=>
        inlet_valve_final_duty_out >= $past(inlet_valve_min_duty_in)) else $error("inlet duty below minimum");
    a_pid_clamp: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        controller_min_in[15:0] <= controller_max_in[15:0] |->
        pid_lim[0] <= controller_max_in[15:0] && pid_lim[0] >= controller_min_in[15:0])
        else $error("pid output outside limits");
    a_manual_path: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        tick && pressure_valve_manual_flag_in && pressure_valve_manual_duty_in <= press_max &&
        pressure_valve_min_duty_in <= pressure_valve_manual_duty_in |=>
        pressure_valve_final_duty_out == $past(pressure_valve_manual_duty_in)) else $error("manual duty not applied");
    a_tick_period: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        tick |=> !tick [*8]) else $error("update ticks too close");
    a_zero_gain: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        proportional_gain_in[15:0] == 16'sh0000 |-> pid_sum[0] == '0) else $error("zero gain left pid output");
endmodule
`default_nettype wire

//--- test/rvdc_ls_model.sv
`timescale 1ns/1ps
`default_nettype none
// low-side channel pair: measures the drive it receives, period and high time
module rvdc_ls_model
    import rvdc_pkg::*;
(
    input wire logic clk_sys_in, // system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic drive_in, // pwm drive from the valve logic
    output logic [FREQ_W-1:0] period_out, // cycles between the last two rises
    output logic [FREQ_W-1:0] high_out // high cycles in that period
);
    logic [FREQ_W-1:0] cnt_r, hcnt_r;
    logic drive_r;
    // first figure after reset or a stopped drive is stale, so readers skip one period
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= '0;
            hcnt_r <= '0;
            drive_r <= 1'b0;
            period_out <= '0;
            high_out <= '0;
        end else begin
            drive_r <= drive_in;
            if (drive_in && !drive_r) begin
                period_out <= cnt_r + 1'b1;
                high_out <= hcnt_r;
                cnt_r <= '0;
                hcnt_r <= 24'h000001;
            end else begin
                cnt_r <= cnt_r + 1'b1;
                hcnt_r <= hcnt_r + {23'h0, drive_in};
            end
        end
    end
endmodule
`default_nettype wire

//--- test/rail_valve_duty_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rail_valve_duty_controller_tb;
    import rvdc_pkg::*;
    // inputs start with the first update's settings: 12 V, 2 ohm and 4 ohm coils
    logic clk = 1'b0, nrst = 1'b0, clr = 1'b0, en_i = 1'b1, en_p = 1'b1, man_i = 1'b0, man_p = 1'b0;
    rvdc_mode_type mode = RVDC_INLET_PID;
    logic signed [VAL_W-1:0] sp = 16'sh0064, pv = 16'sh0032, thr = 16'sh7fff;
    logic [15:0] batt = 16'h2ee0, r_i = 16'h07d0, r_p = 16'h0fa0, ff_i = 16'h1770, ff_p = 16'h05dc;
    logic [15:0] fx_i = 16'h0898, fx_p = 16'h09c4, md_i = 16'h00c8, md_p = 16'h0000;
    logic [15:0] ux_i = 16'h1f40, ux_p = 16'h1f40, mn_i = 16'h0000, mn_p = 16'h0000;
    logic [31:0] kc = 32'h0, cmax = 32'h0bb8_07d0, cmin = 32'h01f4_03e8;
    logic [31:0] ti = 32'h0, td = 32'h0; // time constants never negative
    logic [3:0] ch_i = 4'h3, ch_p = 4'hc, ca_i, ca_p;
    logic [23:0] per_i = 24'h000064, per_p = 24'h0000c8, mp_i, mh_i, mp_p, mh_p;
    logic pw_i, pw_p, flt, tick;
    logic [15:0] fd_i, fd_p, ld_i, ld_p, ce_i, ce_p;
    logic [63:0] psh, ish, dsh;
    int err_total = 0, samples_checked = 0, cyc = 0;

    rvdc_top dut (.clk_sys_in(clk), .nrst_in(nrst), .controlled_valve_select_in(mode), .rail_setpoint_in(sp),
        .rail_pressure_in(pv), .rail_max_thresh_in(thr), .clear_rail_fault_in(clr), .battery_voltage_in(batt),
        .inlet_valve_output_enable_in(en_i), .pressure_valve_output_enable_in(en_p),
        .inlet_valve_channel_assignment_in(ch_i), .pressure_valve_channel_assignment_in(ch_p),
        .inlet_valve_pwm_period_in(per_i), .pressure_valve_pwm_period_in(per_p), .proportional_gain_in(kc),
        .integral_time_in(ti), .derivative_time_in(td), .controller_max_in(cmax), .controller_min_in(cmin),
        .inlet_valve_feed_forward_in(ff_i), .pressure_valve_feed_forward_in(ff_p),
        .inlet_valve_fixed_duty_in(fx_i), .pressure_valve_fixed_duty_in(fx_p),
        .inlet_valve_manual_flag_in(man_i), .pressure_valve_manual_flag_in(man_p),
        .inlet_valve_manual_duty_in(md_i), .pressure_valve_manual_duty_in(md_p),
        .inlet_valve_user_max_duty_in(ux_i), .pressure_valve_user_max_duty_in(ux_p),
        .inlet_valve_min_duty_in(mn_i), .pressure_valve_min_duty_in(mn_p),
        .inlet_valve_coil_resistance_in(r_i), .pressure_valve_coil_resistance_in(r_p),
        .inlet_valve_pwm_out(pw_i), .pressure_valve_pwm_out(pw_p), .inlet_valve_final_duty_out(fd_i),
        .pressure_valve_final_duty_out(fd_p), .inlet_valve_current_limit_duty_out(ld_i),
        .pressure_valve_current_limit_duty_out(ld_p), .inlet_valve_current_estimate_out(ce_i),
        .pressure_valve_current_estimate_out(ce_p), .proportional_share_out(psh), .integral_share_out(ish),
        .derivative_share_out(dsh), .inlet_valve_channel_assignment_out(ca_i),
        .pressure_valve_channel_assignment_out(ca_p), .rail_fault_out(flt), .update_tick_out(tick));
    rvdc_ls_model ls_in (.clk_sys_in(clk), .nrst_in(nrst), .drive_in(pw_i), .period_out(mp_i), .high_out(mh_i));
    rvdc_ls_model ls_pr (.clk_sys_in(clk), .nrst_in(nrst), .drive_in(pw_p), .period_out(mp_p), .high_out(mh_p));

    always #4 clk = ~clk;
    // updates come every 12500 cycles; three of them plus the fault run fit under the ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 50000) begin
            err_total++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // outputs are settled by the falling edge in the cycle of the tick
    task automatic run_tick();
        int n;
        n = 0;
        @(negedge clk);
        while (tick !== 1'b1 && n < 13000) begin
            @(negedge clk);
            n++;
        end
        check("update tick", 32'h1, {31'h0, tick});
    endtask
    // counts cycles in which a drive that should be off is high
    task automatic low_for(input int cycles, output int highs);
        highs = 0;
        repeat (cycles) begin
            @(negedge clk);
            if (pw_i !== 1'b0 || (flt === 1'b1 && pw_p !== 1'b0)) highs++;
        end
    endtask
    // inlet pid: 1000 clamped pid plus 6000 forward, capped by 5000 computed limit
    task automatic t_limits();
        run_tick();
        check("inlet duty", 32'd5000, {16'h0, fd_i});
        check("inlet limit", 32'd5000, {16'h0, ld_i});
        check("inlet current", 32'd3000, {16'h0, ce_i});
        check("inlet shares", 32'h0, psh[31:0] | ish[31:0] | dsh[31:0]);
        check("pressure duty", 32'd2500, {16'h0, fd_p});
        check("pressure limit", 32'd10000, {16'h0, ld_p});
        check("pressure current", 32'd750, {16'h0, ce_p});
        check("channels", 32'h3c, {24'h0, ca_i, ca_p});
        repeat (450) @(negedge clk);
        check("inlet period", 32'd100, {8'h0, mp_i});
        check("inlet high", 32'd50, {8'h0, mh_i});
        check("pressure period", 32'd200, {8'h0, mp_p});
        check("pressure high", 32'd50, {8'h0, mh_p});
    endtask
    // manual 200 is raised to the 400 minimum; pressure manual 800 passes untouched
    task automatic t_manual();
        @(posedge clk);
        man_i <= 1'b1;
        mn_i <= 16'h0190;
        man_p <= 1'b1;
        md_p <= 16'h0320;
        run_tick();
        check("manual duty", 32'd400, {16'h0, fd_i});
        check("manual current", 32'd240, {16'h0, ce_i});
        check("pressure manual duty", 32'd800, {16'h0, fd_p});
        check("pressure manual current", 32'd240, {16'h0, ce_p});
    endtask
    // pressure pid, negative gain, no integral or derivative time
    task automatic t_pressure();
        @(posedge clk);
        man_i <= 1'b0;
        man_p <= 1'b0;
        mn_i <= 16'h0000;
        mode <= RVDC_PRESSURE_PID;
        kc <= 32'hfff0_0000;
        ux_p <= 16'h0708;
        run_tick();
        check("pressure pid duty", 32'd1800, {16'h0, fd_p});
        check("inlet fixed duty", 32'd2200, {16'h0, fd_i});
        check("p share sign", 32'h1, {31'h0, psh[63]});
        check("i share", 32'h0, ish[63:32]);
        check("d share", 32'h0, dsh[63:32]);
    endtask
    // overpressure latches; clearing only works once pressure is back down
    task automatic t_fault();
        int highs;
        @(posedge clk);
        thr <= 16'sh0028;
        repeat (4) @(negedge clk);
        check("fault set", 32'h1, {31'h0, flt});
        low_for(300, highs);
        check("drive during fault", 32'h0, highs);
        @(posedge clk);
        thr <= 16'sh7fff;
        repeat (4) @(negedge clk);
        check("fault held", 32'h1, {31'h0, flt});
        @(posedge clk);
        clr <= 1'b1;
        en_i <= 1'b0;
        @(posedge clk);
        clr <= 1'b0;
        repeat (4) @(negedge clk);
        check("fault cleared", 32'h0, {31'h0, flt});
        low_for(450, highs);
        check("disabled inlet", 32'h0, highs);
        check("pressure resumed", 32'd200, {8'h0, mp_p});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_limits();
        t_manual();
        t_pressure();
        t_fault();
        close_out();
    end
endmodule
`default_nettype wire
